// ### lcdsm_regs.svh
`ifndef LCDSM_REGS_SVH
`define LCDSM_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define LCDSM_ADDR_CTRL 8'h00
`define LCDSM_ADDR_PTR 8'h04
`define LCDSM_ADDR_SUB 8'h08
`define LCDSM_ADDR_DATA 8'h0c
`define LCDSM_ADDR_STAT 8'h10

// ****************************************
// Control fields
// ****************************************
`define LCDSM_CTRL_MODE 1:0
`define LCDSM_CTRL_PSAVE 2
`define LCDSM_CTRL_IN_BANK 3
`define LCDSM_CTRL_OUT_BANK 4
`define LCDSM_CTRL_BLINK 6:5
`define LCDSM_PTR_FIELD 5:0
`define LCDSM_SUB_FIELD 2:0
`define LCDSM_DATA_FIELD 7:0

// ****************************************
// Memory geometry
// ****************************************
`define LCDSM_SEGS 40
`define LCDSM_LAST_ADDR 6'd39
`define LCDSM_HI_BANK 2'h2
`define LCDSM_LAST_BIT 3'h7

// ****************************************
// Timing
// ****************************************
`define LCDSM_SYS_HZ 40000000
`define LCDSM_OSC_HZ_NORM 184320
`define LCDSM_OSC_HZ_PSAVE 30720
`define LCDSM_HALF_NORM (`LCDSM_SYS_HZ / (2 * `LCDSM_OSC_HZ_NORM))
`define LCDSM_HALF_PSAVE (`LCDSM_SYS_HZ / (2 * `LCDSM_OSC_HZ_PSAVE))
`define LCDSM_FRAME_NORM 2880
`define LCDSM_FRAME_PSAVE 480

// ****************************************
// Reset values
// ****************************************
`define LCDSM_BP_RESET 4'h1

`endif

// ### lcdsm_pkg.sv
package lcdsm_pkg;

    typedef enum logic [1:0] {
        LCDSM_STATIC,
        LCDSM_MUX2,
        LCDSM_MUX3,
        LCDSM_MUX4
    } lcdsm_mode_e;

    typedef struct packed {
        lcdsm_mode_e mode;
        logic psave;
        logic in_bank;
        logic out_bank;
        logic [1:0] blink;
        logic [5:0] ptr;
        logic [2:0] sub_cnt;
        logic busy;
        logic [7:0] sreg;
        logic [2:0] bitcnt;
        logic [1:0] pos;
        logic pend;
        logic [7:0] pend_byte;
        logic [10:0] div_cnt;
        logic clk_lvl;
        logic clk_prev;
        logic sync_prev;
        logic sync_drv;
        logic [11:0] tcnt;
        logic [1:0] phase;
        logic [39:0] shreg;
        logic [5:0] sh_idx;
        logic [39:0] latch;
        logic [3:0] bp;
        logic [31:0] rdata;
    } lcdsm_state_s;

endpackage

// ### lcdsm_core.sv
// What this block does
// - Select pin low: run from internal oscillator, drive it out on clock pin.
// - Select pin high: clock pin is input, all timing from it.
// - Frame is device clock divided by 2880, or 480 in power-saving.
// - Byte not yet stored when next arrives: hold serial clock low.
// - Shared sync signal keeps cascaded drivers frame-aligned.
// - Next column shifts in while latched column is displayed.
// - Forty segment outputs from latch bits, in step with backplane phase.
// - Modes use one, two, three or four backplanes.
// - 1:3 backplane 3 copies 1; 1:2 pairs 0 with 2, 1 with 3.
// - Static mode: all four backplanes identical.
// - Memory is 40 words of 4 bits; 1 means segment on.
// - Address maps to segment; word bit n shows against backplane n.
// - Byte fills bit 0 of 8 addresses, or bits 0-1 of 4.
// - 1:3 fills bits 0-2 of 2 addresses and bits 0-1 of a third; 1:4 bits 0-3 of 2.
// - Pointer loaded by command, steps 8, 4, 3 or 2 per byte.
// - Store only when subaddress counter equals strap inputs.
// - On mismatch skip write but step pointer just the same.
// - Pointer overflow past last address increments subaddress counter.
// - Overflow mid-byte sends remaining bits to the next device.
// - Output bank presents bits 0-3, 0-2, 0-1 or 0 per frame.
// - Bank swap shows bit 2 for 0 static, bits 2-3 in 1:2.
// - Reset clears pointer, counter, banks, blink; selects 1:4 mode.
// - Input bank writes bit 2 static or bits 2-3 in 1:2.
`timescale 1ns/1ps
`default_nettype none
`include "lcdsm_regs.svh"

module lcdsm_core (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic osc_sel,
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe,
    output logic scl_hold,
    input wire logic subaddr_strap_0,
    input wire logic subaddr_strap_1,
    input wire logic subaddr_strap_2,
    output logic [39:0] segment_outputs,
    output logic backplane_out_0,
    output logic backplane_out_1,
    output logic backplane_out_2,
    output logic backplane_out_3
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] bits_per_addr(lcdsm_pkg::lcdsm_mode_e m);
        case (m)
            lcdsm_pkg::LCDSM_STATIC: bits_per_addr = 3'h1;
            lcdsm_pkg::LCDSM_MUX2: bits_per_addr = 3'h2;
            lcdsm_pkg::LCDSM_MUX3: bits_per_addr = 3'h3;
            default: bits_per_addr = 3'h4;
        endcase
    endfunction

    function automatic logic [1:0] bank_base(lcdsm_pkg::lcdsm_mode_e m,
                                             logic sel);
        if (sel && (m == lcdsm_pkg::LCDSM_STATIC ||
                    m == lcdsm_pkg::LCDSM_MUX2)) begin
            bank_base = `LCDSM_HI_BANK;
        end else begin
            bank_base = 2'h0;
        end
    endfunction

    function automatic logic [11:0] phase_len(lcdsm_pkg::lcdsm_mode_e m,
                                              logic ps);
        logic [11:0] fr;
        fr = ps ? 12'(`LCDSM_FRAME_PSAVE) : 12'(`LCDSM_FRAME_NORM);
        case (m)
            lcdsm_pkg::LCDSM_STATIC: phase_len = fr;
            lcdsm_pkg::LCDSM_MUX2: phase_len = fr / 12'h2;
            lcdsm_pkg::LCDSM_MUX3: phase_len = fr / 12'h3;
            default: phase_len = fr / 12'h4;
        endcase
    endfunction

    function automatic logic [3:0] bp_pattern(lcdsm_pkg::lcdsm_mode_e m,
                                              logic [1:0] ph);
        case (m)
            lcdsm_pkg::LCDSM_STATIC: bp_pattern = 4'hf;
            lcdsm_pkg::LCDSM_MUX2: bp_pattern = ph[0] ? 4'ha : 4'h5;
            lcdsm_pkg::LCDSM_MUX3: begin
                if (ph == 2'h0) begin
                    bp_pattern = 4'h1;
                end else if (ph == 2'h1) begin
                    bp_pattern = 4'ha;
                end else begin
                    bp_pattern = 4'h4;
                end
            end
            default: bp_pattern = 4'(4'h1 << ph);
        endcase
    endfunction

    function automatic logic [6:0] ptr_step(logic [5:0] p);
        if (p >= `LCDSM_LAST_ADDR) begin
            ptr_step = {1'b1, 6'h0};
        end else begin
            ptr_step = {1'b0, 6'(p + 6'h1)};
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    lcdsm_pkg::lcdsm_state_s st, n;
    logic [3:0] ram [0:`LCDSM_SEGS-1];
    logic ram_we;
    logic [5:0] ram_addr;
    logic [1:0] ram_bit;
    logic ram_val;
    logic tick;
    logic ext_sync;
    logic phase_end;
    logic [2:0] strap;
    logic [2:0] bpa;
    logic [1:0] nxt_phase;
    logic [1:0] out_bit;
    logic [11:0] plen;
    logic [6:0] stepped;

    assign strap = {subaddr_strap_2, subaddr_strap_1, subaddr_strap_0};

    always_comb begin
        n = st;
        ram_we = 1'b0;
        ram_addr = st.ptr;
        ram_bit = 2'(bank_base(st.mode, st.in_bank) + st.pos);
        ram_val = st.sreg[7];
        bpa = bits_per_addr(st.mode);
        plen = phase_len(st.mode, st.psave);
        stepped = ptr_step(st.ptr);
        tick = 1'b0;
        n.rdata = 32'h0;

        // ****************************************
        // Device clock source
        // ****************************************
        n.clk_prev = clk_pin_in;
        if (osc_sel) begin
            tick = clk_pin_in && !st.clk_prev;
            n.clk_lvl = 1'b0;
            n.div_cnt = 11'h0;
        end else if (st.div_cnt == 11'h0) begin
            n.div_cnt = st.psave ? 11'(`LCDSM_HALF_PSAVE - 1)
                                 : 11'(`LCDSM_HALF_NORM - 1);
            n.clk_lvl = !st.clk_lvl;
            tick = !st.clk_lvl;
        end else begin
            n.div_cnt = 11'(st.div_cnt - 11'h1);
        end

        // ****************************************
        // Frame and multiplex timing
        // ****************************************
        // Sync line sampled on device ticks only
        if (tick) begin
            n.sync_prev = sync_in;
        end
        ext_sync = !sync_in && st.sync_prev && !st.sync_drv;
        phase_end = (st.tcnt >= 12'(plen - 12'h1)) || ext_sync;
        if (ext_sync || ({1'b0, st.phase} >= 3'(bpa - 3'h1))) begin
            nxt_phase = 2'h0;
        end else begin
            nxt_phase = 2'(st.phase + 2'h1);
        end
        out_bit = 2'(nxt_phase + bank_base(st.mode, st.out_bank));
        if (tick) begin
            if (phase_end) begin
                n.tcnt = 12'h0;
                n.phase = nxt_phase;
                n.latch = st.shreg;
                n.sh_idx = 6'h0;
                n.bp = bp_pattern(st.mode, nxt_phase);
                n.sync_drv = (nxt_phase == 2'h0) && !ext_sync;
            end else begin
                n.tcnt = 12'(st.tcnt + 12'h1);
                n.sync_drv = 1'b0;
                if (st.sh_idx <= `LCDSM_LAST_ADDR) begin
                    n.shreg = {ram[st.sh_idx][out_bit],
                               st.shreg[39:1]};
                    n.sh_idx = 6'(st.sh_idx + 6'h1);
                end
            end
        end

        // ****************************************
        // Display byte storage
        // ****************************************
        if (tick && st.busy) begin
            if (st.sub_cnt == strap && st.ptr <= `LCDSM_LAST_ADDR) begin
                ram_we = 1'b1;
            end
            n.sreg = {st.sreg[6:0], 1'b0};
            n.bitcnt = 3'(st.bitcnt + 3'h1);
            if ({1'b0, st.pos} == 3'(bpa - 3'h1) ||
                st.bitcnt == `LCDSM_LAST_BIT) begin
                n.pos = 2'h0;
                n.ptr = stepped[5:0];
                if (stepped[6]) begin
                    n.sub_cnt = 3'(st.sub_cnt + 3'h1);
                end
            end else begin
                n.pos = 2'(st.pos + 2'h1);
            end
            if (st.bitcnt == `LCDSM_LAST_BIT) begin
                if (st.pend) begin
                    n.sreg = st.pend_byte;
                    n.bitcnt = 3'h0;
                    n.pend = 1'b0;
                end else begin
                    n.busy = 1'b0;
                end
            end
        end

        // ****************************************
        // Register port
        // ****************************************
        if (reg_wr) begin
            if (reg_addr == `LCDSM_ADDR_CTRL) begin
                n.mode = lcdsm_pkg::lcdsm_mode_e'(reg_wdata[`LCDSM_CTRL_MODE]);
                n.psave = reg_wdata[`LCDSM_CTRL_PSAVE];
                n.in_bank = reg_wdata[`LCDSM_CTRL_IN_BANK];
                n.out_bank = reg_wdata[`LCDSM_CTRL_OUT_BANK];
                n.blink = reg_wdata[`LCDSM_CTRL_BLINK];
            end else if (reg_addr == `LCDSM_ADDR_PTR) begin
                if (reg_wdata[`LCDSM_PTR_FIELD] <= `LCDSM_LAST_ADDR) begin
                    n.ptr = reg_wdata[`LCDSM_PTR_FIELD];
                end else begin
                    n.ptr = 6'h0;
                end
                n.pos = 2'h0;
            end else if (reg_addr == `LCDSM_ADDR_SUB) begin
                n.sub_cnt = reg_wdata[`LCDSM_SUB_FIELD];
            end else if (reg_addr == `LCDSM_ADDR_DATA) begin
                if (!n.busy) begin
                    n.busy = 1'b1;
                    n.sreg = reg_wdata[`LCDSM_DATA_FIELD];
                    n.bitcnt = 3'h0;
                end else if (!n.pend) begin
                    n.pend = 1'b1;
                    n.pend_byte = reg_wdata[`LCDSM_DATA_FIELD];
                end
            end
        end
        if (reg_rd) begin
            if (reg_addr == `LCDSM_ADDR_CTRL) begin
                n.rdata = {25'h0, st.blink, st.out_bank, st.in_bank,
                           st.psave, st.mode};
            end else if (reg_addr == `LCDSM_ADDR_PTR) begin
                n.rdata = {26'h0, st.ptr};
            end else if (reg_addr == `LCDSM_ADDR_SUB) begin
                n.rdata = {29'h0, st.sub_cnt};
            end else if (reg_addr == `LCDSM_ADDR_STAT) begin
                n.rdata = {27'h0, st.phase, st.sub_cnt == strap,
                           st.pend, st.busy};
            end else begin
                n.rdata = 32'h0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.mode <= lcdsm_pkg::LCDSM_MUX4;
            st.bp <= `LCDSM_BP_RESET;
            st.clk_prev <= 1'b1;
            st.sync_prev <= 1'b1;
        end else begin
            st <= n;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ram_we) begin
            ram[ram_addr][ram_bit] <= ram_val;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata = st.rdata;
    assign clk_pin_out = st.clk_lvl;
    assign clk_pin_oe = !osc_sel;
    assign sync_out = 1'b0;
    assign sync_oe = st.sync_drv;
    assign scl_hold = st.pend;
    assign segment_outputs = st.latch;
    assign backplane_out_0 = st.bp[0];
    assign backplane_out_1 = st.bp[1];
    assign backplane_out_2 = st.bp[2];
    assign backplane_out_3 = st.bp[3];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    property p_int_osc;
        !osc_sel |-> clk_pin_oe;
    endproperty
    a_int_osc: assert property (p_int_osc)
        else $error("clock pin not driven with internal oscillator");

    property p_ext_clk;
        osc_sel && !st.clk_prev && clk_pin_in |-> tick && !clk_pin_oe;
    endproperty
    a_ext_clk: assert property (p_ext_clk)
        else $error("external clock edge not used as tick");

    property p_phase_len;
        tick && !(reg_wr && reg_addr == `LCDSM_ADDR_CTRL)
            |=> st.tcnt < plen;
    endproperty
    a_phase_len: assert property (p_phase_len)
        else $error("phase counter ran past its length");

    property p_stretch;
        reg_wr && reg_addr == `LCDSM_ADDR_DATA && st.busy && !st.pend &&
            !(tick && st.bitcnt == `LCDSM_LAST_BIT) |=> scl_hold;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("no clock stretch while byte pending");

    property p_latch;
        tick && phase_end |=> segment_outputs == $past(st.shreg);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latch not loaded from shift register");

    property p_mux3_bp;
        st.mode == lcdsm_pkg::LCDSM_MUX3 && $stable(st.mode) && tick &&
            phase_end |=> backplane_out_3 == backplane_out_1;
    endproperty
    a_mux3_bp: assert property (p_mux3_bp)
        else $error("backplane 3 differs from 1 in 1:3");

    property p_static_bp;
        st.mode == lcdsm_pkg::LCDSM_STATIC && tick && phase_end
            |=> st.bp == 4'hf;
    endproperty
    a_static_bp: assert property (p_static_bp)
        else $error("static backplanes differ");

    property p_match;
        ram_we |-> st.sub_cnt == strap;
    endproperty
    a_match: assert property (p_match)
        else $error("store with subaddress mismatch");

    property p_ovf;
        tick && st.busy && stepped[6] && !reg_wr &&
            (st.bitcnt == `LCDSM_LAST_BIT || {1'b0, st.pos} == bpa - 3'h1)
            |=> st.sub_cnt == 3'($past(st.sub_cnt) + 3'h1) && st.ptr == 6'h0;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow did not advance subaddress");

    c_store: cover property (ram_we);
    c_stretch: cover property (scl_hold ##1 !scl_hold);
    c_ovf: cover property (tick && st.busy && stepped[6]);
    c_mux3: cover property (st.mode == lcdsm_pkg::LCDSM_MUX3 && phase_end);

endmodule

`default_nettype wire

// ### lcdsm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcdsm_regs.svh"

module lcdsm_host_model #(
    parameter int POR_WAIT = 40
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [31:0] reg_rdata,
    input wire logic scl_hold,
    output var logic [7:0] reg_addr,
    output var logic [31:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    output logic ext_clk
);
    // ****************************************
    // Device clock and start-up quiet time
    // ****************************************
    logic [1:0] div = 2'h0;
    int quiet = 0;

    always @(posedge sys_clk) begin
        div <= div + 2'h1;
    end
    assign ext_clk = div[1];

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            quiet <= 0;
        end else if (quiet < POR_WAIT) begin
            quiet <= quiet + 1;
        end
    end

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        while (quiet < POR_WAIT) @(posedge sys_clk);
        if (a == `LCDSM_ADDR_DATA) begin
            @(negedge sys_clk);
            while (scl_hold !== 1'b0) @(negedge sys_clk);
        end
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        while (quiet < POR_WAIT) @(posedge sys_clk);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcdsm_regs.svh"

module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic osc_sel = 1'b1;
    logic sync_ext = 1'b0;
    logic [2:0] strap = 3'h5;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd, ext_clk, clk_pin, clk_pin_out, clk_pin_oe;
    logic sync_in, sync_out, sync_oe, scl_hold;
    logic [39:0] seg;
    logic [3:0] bp;
    int mismatches = 0;
    int num_checks = 0;

    always #12.5 sys_clk = ~sys_clk;
    assign clk_pin = clk_pin_oe ? clk_pin_out : ext_clk;
    assign sync_in = ~((sync_oe & ~sync_out) | sync_ext);

    lcdsm_host_model i_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_rdata(reg_rdata), .scl_hold(scl_hold), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .ext_clk(ext_clk));

    lcdsm_core i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_sel(osc_sel),
        .clk_pin_in(clk_pin), .clk_pin_out(clk_pin_out),
        .clk_pin_oe(clk_pin_oe), .sync_in(sync_in), .sync_out(sync_out),
        .sync_oe(sync_oe), .scl_hold(scl_hold),
        .subaddr_strap_0(strap[0]), .subaddr_strap_1(strap[1]),
        .subaddr_strap_2(strap[2]), .segment_outputs(seg),
        .backplane_out_0(bp[0]), .backplane_out_1(bp[1]),
        .backplane_out_2(bp[2]), .backplane_out_3(bp[3]));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic setc(input logic [1:0] m, input logic ps, ib, ob);
        i_host.wr(`LCDSM_ADDR_CTRL, {27'h0, ob, ib, ps, m});
    endtask

    task automatic put(input logic [5:0] p, input logic [7:0] b);
        i_host.wr(`LCDSM_ADDR_PTR, {26'h0, p});
        i_host.wr(`LCDSM_ADDR_DATA, {24'h0, b});
    endtask

    task automatic idle;
        int i;
        for (i = 0; i < 64; i++) begin
            i_host.rd(`LCDSM_ADDR_STAT, rv);
            if (rv[1:0] === 2'h0) break;
        end
        chk({30'h0, rv[1:0]}, 32'h0);
    endtask

    task automatic show(input int k, input logic [7:0] msk, exp);
        int i;
        repeat (3900) @(negedge sys_clk);
        for (i = 0; i < 2000 && bp[k] !== 1'b1; i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        chk({24'h0, seg[7:0] & msk}, {24'h0, exp});
    endtask

    task automatic sync_rise(output int c);
        c = 0;
        while (sync_oe !== 1'b0 && c < 30000) begin
            @(negedge sys_clk);
            c++;
        end
        while (sync_oe !== 1'b1 && c < 30000) begin
            @(negedge sys_clk);
            c++;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        @(negedge sys_clk);
        chk({28'h0, bp}, {28'h0, `LCDSM_BP_RESET});
        chk(seg[31:0], 32'h0);
        rchk(`LCDSM_ADDR_CTRL, 32'h3);
        rchk(`LCDSM_ADDR_PTR, 32'h0);
        rchk(`LCDSM_ADDR_SUB, 32'h0);
        rchk(8'h20, 32'h0);
        $display("done reset");
    endtask

    task automatic t_clk;
        int n;
        logic p;
        n = 0;
        @(posedge sys_clk);
        osc_sel <= 1'b0;
        @(negedge sys_clk);
        chk({31'h0, clk_pin_oe}, 32'h1);
        p = clk_pin_out;
        repeat (1000) begin
            @(negedge sys_clk);
            if (clk_pin_out !== p) n++;
            p = clk_pin_out;
        end
        chk({31'h0, n >= 1000 / `LCDSM_HALF_NORM - 1 &&
            n <= 1000 / `LCDSM_HALF_NORM + 1}, 32'h1);
        @(posedge sys_clk);
        osc_sel <= 1'b1;
        @(negedge sys_clk);
        chk({31'h0, clk_pin_oe}, 32'h0);
        $display("done clock");
    endtask

    task automatic t_frame;
        int c, ps;
        for (ps = 0; ps < 2; ps++) begin
            setc(2'h3, ps[0], 1'b0, 1'b0);
            sync_rise(c);
            sync_rise(c);
            chk(c, ps ? `LCDSM_FRAME_PSAVE * 4 : `LCDSM_FRAME_NORM * 4);
        end
        sync_rise(c);
        repeat (200) @(posedge sys_clk);
        sync_ext <= 1'b1;
        sync_rise(c);
        chk({31'h0, c >= `LCDSM_FRAME_PSAVE * 4 &&
            c <= `LCDSM_FRAME_PSAVE * 4 + 8}, 32'h1);
        @(posedge sys_clk);
        sync_ext <= 1'b0;
        $display("done frame");
    endtask

    task automatic t_modes;
        logic [15:0] exp [4] = '{16'h8000, 16'h0420, 16'h0412, 16'h0116};
        logic [15:0] seen;
        int m;
        for (m = 0; m < 4; m++) begin
            setc(m[1:0], 1'b1, 1'b0, 1'b0);
            repeat (2000) @(negedge sys_clk);
            seen = 16'h0;
            repeat (1920) begin
                @(negedge sys_clk);
                seen[bp] = 1'b1;
            end
            chk({16'h0, seen}, {16'h0, exp[m]});
        end
        $display("done modes");
    endtask

    task automatic t_store;
        logic [7:0] col [4] = '{8'h09, 8'h0a, 8'h05, 8'h06};
        logic [31:0] step [4] = '{32'h8, 32'h4, 32'h3, 32'h2};
        int k;
        setc(2'h3, 1'b1, 1'b0, 1'b0);
        i_host.wr(`LCDSM_ADDR_SUB, 32'h5);
        put(6'h00, 8'ha5);
        i_host.wr(`LCDSM_ADDR_DATA, 32'h3c);
        @(negedge sys_clk);
        chk({31'h0, scl_hold}, 32'h1);
        idle();
        rchk(`LCDSM_ADDR_PTR, 32'h4);
        for (k = 0; k < 4; k++) show(k, 8'h0f, col[k]);
        i_host.wr(`LCDSM_ADDR_SUB, 32'h4);
        put(6'h00, 8'hff);
        idle();
        rchk(`LCDSM_ADDR_PTR, 32'h2);
        show(0, 8'h0f, 8'h09);
        i_host.wr(`LCDSM_ADDR_SUB, 32'h5);
        put(6'h26, 8'h00);
        idle();
        rchk(`LCDSM_ADDR_PTR, 32'h0);
        rchk(`LCDSM_ADDR_SUB, 32'h6);
        setc(2'h2, 1'b1, 1'b0, 1'b0);
        i_host.wr(`LCDSM_ADDR_SUB, 32'h5);
        put(6'h27, 8'h00);
        idle();
        rchk(`LCDSM_ADDR_PTR, 32'h2);
        rchk(`LCDSM_ADDR_SUB, 32'h6);
        for (k = 0; k < 4; k++) begin
            setc(k[1:0], 1'b1, 1'b0, 1'b0);
            put(6'h00, 8'h00);
            idle();
            rchk(`LCDSM_ADDR_PTR, step[k]);
        end
        $display("done store");
    endtask

    task automatic t_bank;
        setc(2'h0, 1'b1, 1'b1, 1'b0);
        i_host.wr(`LCDSM_ADDR_SUB, 32'h5);
        put(6'h00, 8'h96);
        idle();
        rchk(`LCDSM_ADDR_PTR, 32'h8);
        show(0, 8'h0f, 8'h09);
        setc(2'h0, 1'b1, 1'b1, 1'b1);
        show(0, 8'hff, 8'h69);
        $display("done bank");
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_clk();
        t_frame();
        t_modes();
        t_store();
        t_bank();
        conclude();
    end
endmodule

`default_nettype wire
